// ===== hdl/i2c_master_pkg.sv
// constants, command codes and timing counts of the two-wire bus master
// Contract
// (R01) master only, drives the clock line always
// (R02) standard and fast bit rates selectable
// (R03) no arbitration; wait while slave holds clock
// (R04) data line open-drain: pull low or release
// (R05) bytes of eight bits, msb first
// (R06) ninth clock carries the acknowledge bit
// (R07) master starts transfers and makes every clock
// (R08) each transfer opens with start, ends stop
// (R09) data changes only while clock is low
// (R10) start: data falls while clock high
// (R11) stop: data rises while clock high
// (R12) receiving: pull data low to acknowledge
// (R13) slave releases data during master acknowledge
// (R14) unable to accept: leave data released
// (R15) final read byte answered with not-acknowledge
// (R16) write: start, address+0, index, data, stop
// (R17) slave acknowledges address, index and data
// (R18) multi-byte write sends several data bytes
// (R19) read: index write, repeated start, address+1
// (R20) single read: not-acknowledge then stop
// (R21) multi read: acknowledge all but last
// (R22) byte command port with done, nack status
package i2c_master_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_KHZ   = 200000;
	localparam int STD_KBPS  = 100;
	localparam int FAST_KBPS = 400;
	localparam int QTR_PER_BIT = 4;
	localparam int QTR_STD   = CLK_KHZ / (STD_KBPS * QTR_PER_BIT);
	localparam int QTR_FAST  = CLK_KHZ / (FAST_KBPS * QTR_PER_BIT);
	localparam int QCNT_W    = 10;

	// ------------------------------------------------------------
	// command words
	// ------------------------------------------------------------
	localparam logic [1:0] CMD_START = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_READ  = 2'h2;
	localparam logic [1:0] CMD_STOP  = 2'h3;
	localparam int CMD_W      = 11;
	localparam int CMD_CODE_H = 10;
	localparam int CMD_CODE_L = 9;
	localparam int CMD_LAST   = 8;
	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 8;

	// ------------------------------------------------------------
	// reset values and last bit index
	// ------------------------------------------------------------
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;

endpackage

// ===== hdl/cmd_fifo.sv
// synchronous fifo with valid/ready on both sides and registered in_ready
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             in_ready_r;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready_r;
	assign pop       = out_valid && out_ready;
	assign in_ready  = in_ready_r;
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			count_r    <= '0;
			in_ready_r <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
		end
	end

endmodule
`default_nettype wire

// ===== hdl/i2c_master_controller.sv
// single-master two-wire bus controller with a byte command port
`timescale 1ns/1ps
`default_nettype none
module i2c_master_controller #(
	parameter int STD_QTR  = i2c_master_pkg::QTR_STD,
	parameter int FAST_QTR = i2c_master_pkg::QTR_FAST,
	parameter int DEPTH    = i2c_master_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              rstn,
	// command port
	input  wire logic                              cmd_valid,
	output logic                                   cmd_ready,
	input  wire logic [1:0]                        cmd_code,
	input  wire logic                              cmd_last,
	input  wire logic [i2c_master_pkg::BYTE_W-1:0] cmd_data,
	input  wire logic                              fast_mode,
	// read data
	output logic [i2c_master_pkg::BYTE_W-1:0]      rd_data,
	output logic                                   rd_valid,
	input  wire logic                              rd_ready,
	// status
	output logic                                   busy,
	output logic                                   done,
	output logic                                   ack_err,
	// bus pins
	output logic                                   scl_out,
	input  wire logic                              scl_in,
	input  wire logic                              sda_in,
	output logic                                   sda_out,
	output logic                                   sda_oe
);
	import i2c_master_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b010,
		ST_ACK   = 3'b011,
		ST_STOP  = 3'b100
	} eng_state_t;

	// ------------------------------------------------------------
	// command fifo
	// ------------------------------------------------------------
	logic              f_valid;
	logic              f_ready;
	logic [CMD_W-1:0]  f_data;
	logic              cmd_ready_w;

	cmd_fifo #(
		.WIDTH (CMD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready_w),
		.in_data   ({cmd_code, cmd_last, cmd_data}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// in_ready is already a register inside the fifo
	assign cmd_ready = cmd_ready_w;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic scl_meta_r;
	logic scl_s_r;
	logic sda_meta_r;
	logic sda_s_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_meta_r <= 1'b1;
			scl_s_r    <= 1'b1;
			sda_meta_r <= 1'b1;
			sda_s_r    <= 1'b1;
		end else begin
			scl_meta_r <= scl_in;
			scl_s_r    <= scl_meta_r;
			sda_meta_r <= sda_in;
			sda_s_r    <= sda_meta_r;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	eng_state_t        state_r;
	logic [1:0]        phase_r;
	logic [QCNT_W-1:0] qcnt_r;
	logic [2:0]        bit_cnt_r;
	logic [BYTE_W-1:0] shift_r;
	logic              is_read_r;
	logic              last_r;
	logic              ack_low_r;
	logic              bus_open_r;
	logic [QCNT_W-1:0] qtr_load;
	logic              tick;
	logic              stall;
	logic              step_end;
	logic              rx_take;
	logic [BYTE_W-1:0] rx_byte;

	assign qtr_load = fast_mode ? QCNT_W'(FAST_QTR - 1) : QCNT_W'(STD_QTR - 1); // R02
	// clock released but line still low: slave is stretching
	assign stall    = phase_r[1] && !scl_s_r; // R03
	assign tick     = (qcnt_r == '0) && !stall;
	assign step_end = tick && (phase_r == 2'h3);
	assign f_ready  = (state_r == ST_IDLE);
	assign rx_byte  = shift_r;
	assign rx_take  = step_end && (state_r == ST_ACK) && is_read_r && !rd_valid;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r    <= ST_IDLE;
			phase_r    <= 2'h0;
			qcnt_r     <= '0;
			bit_cnt_r  <= 3'h0;
			shift_r    <= BYTE_RST;
			is_read_r  <= 1'b0;
			last_r     <= 1'b0;
			ack_low_r  <= 1'b0;
			bus_open_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					phase_r   <= 2'h0;
					qcnt_r    <= qtr_load;
					bit_cnt_r <= 3'h0;
					if (f_valid) begin
						is_read_r <= (f_data[CMD_CODE_H:CMD_CODE_L] == CMD_READ);
						last_r    <= f_data[CMD_LAST];
						shift_r   <= f_data[BYTE_W-1:0];
						case (f_data[CMD_CODE_H:CMD_CODE_L])
							CMD_START: state_r <= ST_START; // R08 R19
							CMD_WRITE: state_r <= ST_DATA;  // R16 R18
							CMD_READ:  state_r <= ST_DATA;
							CMD_STOP:  state_r <= ST_STOP;  // R08
							default:   state_r <= ST_IDLE;
						endcase
					end
				end
				ST_START, ST_DATA, ST_ACK, ST_STOP: begin
					if (stall) begin
						qcnt_r <= qcnt_r;
					end else if (qcnt_r != '0) begin
						qcnt_r <= qcnt_r - 1'b1;
					end else begin
						qcnt_r  <= qtr_load;
						phase_r <= phase_r + 1'b1;
						if (phase_r == 2'h3) begin
							case (state_r)
								ST_START: begin
									bus_open_r <= 1'b1;
									state_r    <= ST_IDLE;
								end
								ST_DATA: begin
									// sample at the end of clock high, msb first
									shift_r <= {shift_r[BYTE_W-2:0], sda_s_r}; // R05
									if (bit_cnt_r == BIT_LAST) begin
										state_r   <= ST_ACK; // R06
										// R12 R14 R15 R21
										ack_low_r <= is_read_r && !last_r && !rd_valid;
									end else begin
										bit_cnt_r <= bit_cnt_r + 1'b1;
									end
								end
								ST_STOP: begin
									bus_open_r <= 1'b0;
									state_r    <= ST_IDLE;
								end
								default: begin
									state_r <= ST_IDLE;
								end
							endcase
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// line drive
	// ------------------------------------------------------------
	logic scl_hi_nxt;
	logic sda_low_nxt;
	logic scl_out_r;
	logic sda_oe_r;
	logic sda_out_r;

	// phase 0 clock low, 1 data set, 2 and 3 clock high
	always_comb begin
		scl_hi_nxt  = phase_r[1]; // R07
		sda_low_nxt = sda_oe_r;
		case (state_r)
			ST_IDLE: begin
				scl_hi_nxt  = !bus_open_r;
				sda_low_nxt = sda_oe_r;
			end
			ST_START: begin
				// release high with clock low, fall while clock high
				sda_low_nxt = (phase_r == 2'h0) ? sda_oe_r : (phase_r == 2'h3); // R10
			end
			ST_DATA: begin
				if (phase_r != 2'h0) begin
					sda_low_nxt = !is_read_r && !shift_r[BYTE_W-1]; // R09
				end
			end
			ST_ACK: begin
				if (phase_r != 2'h0) begin
					sda_low_nxt = is_read_r && ack_low_r; // R12 R14 R20
				end
			end
			ST_STOP: begin
				// low with clock low, released while clock high
				if (phase_r != 2'h0) begin
					sda_low_nxt = (phase_r != 2'h3); // R11
				end
			end
			default: begin
				scl_hi_nxt  = 1'b1;
				sda_low_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_out_r <= 1'b1;
			sda_oe_r  <= 1'b0;
			sda_out_r <= 1'b0;
		end else begin
			scl_out_r <= scl_hi_nxt;  // R01
			sda_oe_r  <= sda_low_nxt; // R04
			sda_out_r <= 1'b0;
		end
	end

	assign scl_out = scl_out_r;
	assign sda_oe  = sda_oe_r;
	assign sda_out = sda_out_r;

	// ------------------------------------------------------------
	// read data and status
	// ------------------------------------------------------------
	logic [BYTE_W-1:0] rd_data_r;
	logic              rd_valid_r;
	logic              busy_r;
	logic              done_r;
	logic              ack_err_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_r  <= BYTE_RST;
			rd_valid_r <= 1'b0;
		end else begin
			if (rx_take) begin
				rd_data_r  <= rx_byte;
				rd_valid_r <= 1'b1;
			end else if (rd_valid_r && rd_ready) begin
				rd_valid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			ack_err_r <= 1'b0;
		end else begin
			busy_r <= (state_r != ST_IDLE) || f_valid;
			done_r <= step_end && (state_r != ST_DATA); // R22
			if (step_end && (state_r == ST_ACK) && !is_read_r && sda_s_r) begin
				ack_err_r <= 1'b1; // R17 R22
			end else if ((state_r == ST_IDLE) && f_valid
					&& (f_data[CMD_CODE_H:CMD_CODE_L] == CMD_START)) begin
				ack_err_r <= 1'b0;
			end
		end
	end

	assign rd_data  = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign busy     = busy_r;
	assign done     = done_r;
	assign ack_err  = ack_err_r;

endmodule
`default_nettype wire

// ===== sim/i2c_master_controller_checker.sv
// bus pin and status assertions for the two-wire master
`timescale 1ns/1ps
`default_nettype none
module i2c_master_controller_checker #(
	parameter int STD_QTR  = i2c_master_pkg::QTR_STD,
	parameter int FAST_QTR = i2c_master_pkg::QTR_FAST
) (
	input wire logic                              sys_clk,
	input wire logic                              rstn,
	input wire logic                              fast_mode,
	input wire logic                              scl_out,
	input wire logic                              scl_in,
	input wire logic                              sda_out,
	input wire logic                              sda_oe,
	input wire logic                              done,
	input wire logic                              rd_valid,
	input wire logic                              rd_ready,
	input wire logic [i2c_master_pkg::BYTE_W-1:0] rd_data
);
	localparam int LOW_MIN = 2 * FAST_QTR - 1;
	localparam int LOW_STD = 2 * STD_QTR - 1;
	int low_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// clock low time counter
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			low_r <= 0;
		else
			low_r <= scl_out ? 0 : low_r + 1;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_rise_data_stable: assert property ($rose(scl_out) |-> $stable(sda_oe))
		else $error("data moved as the clock rose");
	a_fall_data_stable: assert property ($fell(scl_out) |-> $stable(sda_oe))
		else $error("data moved as the clock fell");
	a_start_hold: assert property (scl_out && $rose(sda_oe) |=> (scl_out && sda_oe) [*3])
		else $error("start condition not held");
	a_stop_release: assert property (scl_out && $fell(sda_oe) |=> (scl_out && !sda_oe) [*3])
		else $error("stop condition not held");
	a_stretch_wait: assert property (scl_out && !scl_in |=> scl_out)
		else $error("clock dropped while held by slave");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data driven high");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_read_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("read byte lost before taken");
	a_scl_low_time: assert property ($rose(scl_out) |->
		low_r >= (fast_mode ? LOW_MIN : LOW_STD))
		else $error("clock low period too short");
	c_done: cover property (done);
	c_read: cover property (rd_valid && rd_ready);
	c_stretch: cover property (scl_out && !scl_in);
endmodule
bind i2c_master_controller i2c_master_controller_checker #(
	.STD_QTR(STD_QTR),
	.FAST_QTR(FAST_QTR)
) chk (.sys_clk, .rstn, .fast_mode, .scl_out, .scl_in, .sda_out, .sda_oe, .done, .rd_valid,
	.rd_ready, .rd_data);
`default_nettype wire

// ===== sim/i2c_slave_model.sv
// two-wire slave with byte memory and optional clock stretching
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic stretch,
	output logic      sda_pull,
	output logic      scl_hold
);
	logic [7:0] mem [256];
	logic [7:0] sh;
	logic [7:0] idx;
	logic       act;
	logic       rd;
	logic       mack;
	int         cnt;
	int         nbyte;
	int         acks;
	initial begin
		sda_pull = 0;
		scl_hold = 0;
		act = 0;
	end
	// ----------------------------------------
	// framing
	// ----------------------------------------
	always @(negedge sda) if (scl) begin
		act = 1;
		rd = 0;
		// the start's own clock fall is not a bit
		cnt = -1;
		nbyte = 0;
		acks = 0;
	end
	always @(posedge sda) if (scl)
		act = 0;
	always @(posedge scl) if (act) begin
		if (cnt < 8 && !rd)
			sh = {sh[6:0], sda};
		if (cnt == 8 && rd && nbyte > 1) begin
			mack = !sda;
			acks += mack;
		end
	end
	always @(negedge scl) if (act) begin
		if (cnt == 8) begin
			cnt = 0;
			sda_pull = 0;
			if (rd && (nbyte == 1 || mack)) begin
				sh = mem[idx];
				idx = idx + 8'h01;
				sda_pull = !sh[7];
			end
		end else if (cnt == 7) begin
			cnt = 8;
			sda_pull = 0;
			if (!rd) begin
				sda_pull = nbyte > 0 || sh[7:1] == ADDR;
				act = sda_pull;
				if (nbyte == 0)
					rd = sh[0];
				else if (nbyte == 1)
					idx = sh;
				else begin
					mem[idx] = sh;
					idx = idx + 8'h01;
				end
			end
			nbyte++;
		end else begin
			cnt++;
			if (rd)
				sda_pull = !sh[7 - cnt];
		end
	end
	always @(negedge scl) if (act && stretch) begin
		scl_hold = 1;
		#400 scl_hold = 0;
	end
endmodule
`default_nettype wire

// ===== sim/test_i2c_master_controller.sv
// self-checking bench: command stream against the slave model
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_controller;
	import i2c_master_pkg::*;
	localparam logic [6:0] SLV = 7'h2A;
	logic       sys_clk, rstn, cmd_valid, cmd_ready, cmd_last, fast_mode, rd_valid, rd_ready;
	logic       busy, done, ack_err, scl_out, sda_out, sda_oe, stretch, sda_pull, scl_hold;
	logic [1:0] cmd_code;
	logic [7:0] cmd_data, rd_data;
	logic [7:0] got [$];
	logic [7:0] rows [4][3] = '{'{8'h10, 8'hA5, 8'h5A}, '{8'h21, 8'h80, 8'h01},
		'{8'hFE, 8'hFF, 8'h00}, '{8'h3C, 8'h96, 8'h69}};
	int         fail_count, num_checks, ndone;
	wire        scl_bus = scl_out & ~scl_hold;
	wire        sda_bus = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
	i2c_master_controller #(.STD_QTR(8), .FAST_QTR(6), .DEPTH(FIFO_DEPTH)) dut (.sys_clk,
		.rstn, .cmd_valid, .cmd_ready, .cmd_code, .cmd_last, .cmd_data, .fast_mode, .rd_data,
		.rd_valid, .rd_ready, .busy, .done, .ack_err, .scl_out, .scl_in(scl_bus),
		.sda_in(sda_bus), .sda_out, .sda_oe);
	i2c_slave_model #(.ADDR(SLV)) slave (.scl(scl_bus), .sda(sda_bus), .stretch, .sda_pull,
		.scl_hold);
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (done)
			ndone++;
		if (rd_valid && rd_ready)
			got.push_back(rd_data);
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic conclude;
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [1:0] c, input logic l, input logic [7:0] d);
		int n;
		cmd_valid = 1;
		cmd_code = c;
		cmd_last = l;
		cmd_data = d;
		for (n = 0; n < 9000 && !cmd_ready; n++)
			@(negedge sys_clk);
		if (!cmd_ready) begin
			check("cmd_ready wait", 0, 1);
			conclude;
		end
		@(negedge sys_clk);
	endtask
	task automatic settle;
		int n;
		cmd_valid = 0;
		repeat (3) @(negedge sys_clk);
		for (n = 0; n < 20000 && busy !== 0; n++)
			@(negedge sys_clk);
		if (busy !== 0) begin
			fail_count++;
			conclude;
		end
	endtask
	task automatic seek(input logic [7:0] i, input logic rdir);
		put(CMD_START, 0, 0);
		put(CMD_WRITE, 0, {SLV, 1'b0});
		put(CMD_WRITE, 0, i);
		if (rdir) begin
			put(CMD_START, 0, 0);
			put(CMD_WRITE, 0, {SLV, 1'b1});
		end
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		sys_clk = 0;
		{rstn, cmd_valid, cmd_code, cmd_last, cmd_data, fast_mode, stretch} = '0;
		rd_ready = 1;
		repeat (2) @(negedge sys_clk);
		check("scl_out in reset", scl_out, 1);
		check("sda_oe in reset", sda_oe, 0);
		rstn = 1;
		@(negedge sys_clk);
		put(CMD_START, 0, 0);
		put(CMD_WRITE, 0, {~SLV, 1'b0});
		put(CMD_STOP, 0, 0);
		settle;
		check("ack_err", ack_err, 1);
		check("done pulses", 8'(ndone), 3);
		for (int r = 0; r < 4; r++) begin
			fast_mode = r[0];
			stretch = r[1];
			ndone = 0;
			seek(rows[r][0], 0);
			put(CMD_WRITE, 0, rows[r][1]);
			put(CMD_WRITE, 0, rows[r][2]);
			put(CMD_STOP, 0, 0);
			seek(rows[r][0], 1);
			put(CMD_READ, 0, 0);
			put(CMD_READ, 1, 0);
			put(CMD_STOP, 0, 0);
			settle;
			check("ack_err", ack_err, 0);
			check("done pulses", 8'(ndone), 14);
			check("bytes read", 8'(got.size()), 2);
			check("first byte", got.pop_front(), rows[r][1]);
			check("second byte", got.pop_front(), rows[r][2]);
			check("slave memory", slave.mem[rows[r][0]], rows[r][1]);
			check("master acks", 8'(slave.acks), 1);
			check("final acknowledge", slave.mack, 0);
			check("idle clock", scl_bus, 1);
			check("idle data", sda_bus, 1);
		end
		rd_ready = 0;
		seek(rows[1][0], 1);
		put(CMD_READ, 0, 0);
		put(CMD_READ, 0, 0);
		put(CMD_STOP, 0, 0);
		settle;
		check("held rd_valid", rd_valid, 1);
		check("held byte", rd_data, rows[1][1]);
		check("refused byte", slave.mack, 0);
		check("master acks", 8'(slave.acks), 1);
		rd_ready = 1;
		repeat (3) @(negedge sys_clk);
		check("rd_valid taken", rd_valid, 0);
		put(CMD_START, 0, 0);
		put(CMD_WRITE, 0, 8'hC3);
		cmd_valid = 0;
		repeat (100) @(negedge sys_clk);
		rstn = 0;
		@(negedge sys_clk);
		check("scl_out after reset", scl_out, 1);
		check("sda_oe after reset", sda_oe, 0);
		check("busy after reset", busy, 0);
		conclude;
	end
endmodule
`default_nettype wire
